/* File: prgseq_top.sv */
// program counter, paging, return stack and indirect data addressing
//
// What this block does
// - counter increments each cycle unless loaded
// - jump loads counter bits 8:0 from instruction
// - counter low byte readable and writable as register
// - status bit 5 supplies counter bit 9
// - call or low-byte write clears bit 8
// - reset puts counter at last memory word
// - counter wraps to zero after reset instruction
// - reset clears the page preselect bit
// - return stack has two 12-bit levels
// - call shifts level one down, pushes return
// - deeper calls silently drop oldest addresses
// - return pops level one, copies level two up
// - extra returns keep repeating level two address
// - return loads working register with literal
// - no flag for stack overflow or underflow
// - indirect port accesses register pointer selects
// - indirect read of the port yields zero
// - indirect write to the port stores nothing
// - pointer low five bits address, upper bits bank
// - page bit set means upper page
`timescale 1ns/1ps
`default_nettype none
module prgseq_top (
  input  wire logic                           CLK_I,
  input  wire logic                           RST_N_I,
  input  wire logic                           JUMP_I,
  input  wire logic                           CALL_I,
  input  wire logic                           RET_I,
  input  wire logic [8:0]                     BR_ADDR_I,
  input  wire logic [prgseq_pkg::DATA_W-1:0]  RET_LIT_I,
  input  wire logic                           RF_RD_I,
  input  wire logic                           RF_WR_I,
  input  wire logic [prgseq_pkg::FILE_W-1:0]  RF_ADDR_I,
  input  wire logic [prgseq_pkg::DATA_W-1:0]  RF_WDATA_I,
  input  wire logic [prgseq_pkg::DATA_W-1:0]  MEM_RDATA_I,
  output logic      [prgseq_pkg::PC_W-1:0]    PC_O,
  output logic                                PAGE_O,
  output logic      [prgseq_pkg::PTR_W-1:0]   PTR_O,
  output logic                                W_LOAD_O,
  output logic      [prgseq_pkg::DATA_W-1:0]  W_DATA_O,
  output logic                                MEM_RD_O,
  output logic                                MEM_WR_O,
  output logic      [prgseq_pkg::MADDR_W-1:0] MEM_ADDR_O,
  output logic      [prgseq_pkg::DATA_W-1:0]  MEM_WDATA_O,
  output logic                                RD_VALID_O,
  output logic      [prgseq_pkg::DATA_W-1:0]  RD_DATA_O
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [prgseq_pkg::PC_W-1:0]    pc_ff;
  logic [prgseq_pkg::PC_W-1:0]    nxt_pc;
  logic                           page_ff;
  logic [prgseq_pkg::PTR_W-1:0]   ptr_ff;
  logic                           wload_ff;
  logic [prgseq_pkg::DATA_W-1:0]  wdata_ff;
  logic                           mem_rd_ff;
  logic                           mem_wr_ff;
  logic [prgseq_pkg::MADDR_W-1:0] mem_addr_ff;
  logic [prgseq_pkg::DATA_W-1:0]  mem_wdata_ff;
  logic                           rd_pend_ff;
  prgseq_pkg::prgseq_src_t        rd_src_ff;
  logic [prgseq_pkg::DATA_W-1:0]  pcl_snap_ff;
  logic                           rd_valid_ff;
  logic [prgseq_pkg::DATA_W-1:0]  rd_data_ff;
  logic [prgseq_pkg::STK_W-1:0]   stk_top;
  logic [prgseq_pkg::STK_W-1:0]   stk_lvl2;
  logic [prgseq_pkg::STK_W-1:0]   ret_addr;
  logic                           indirect;
  logic                           null_acc;
  logic [prgseq_pkg::FILE_W-1:0]  eff_file;
  logic [prgseq_pkg::MADDR_W-1:0] eff_addr;
  logic                           pcl_wr;
  logic                           ptr_wr;
  logic                           stat_wr;
  logic                           local_acc;

  // ****************************************************************
  // address resolution for the data register access
  // ****************************************************************
  // the indirect port has no storage: its address is swapped for the pointer
  assign indirect = (RF_ADDR_I == prgseq_pkg::ADDR_INDIRECT);
  assign eff_file = indirect ? ptr_ff[prgseq_pkg::FILE_W-1:0] : RF_ADDR_I;
  assign null_acc = indirect && (eff_file == prgseq_pkg::ADDR_INDIRECT);
  // bank bits only steer indirect accesses; direct ones stay in bank zero
  assign eff_addr = indirect ? {ptr_ff[prgseq_pkg::PTR_W-1:prgseq_pkg::FILE_W], eff_file}
                             : {{prgseq_pkg::BANK_W{1'b0}}, eff_file};
  assign pcl_wr   = RF_WR_I && !null_acc && (eff_file == prgseq_pkg::ADDR_PCL);
  assign ptr_wr   = RF_WR_I && !null_acc && (eff_file == prgseq_pkg::ADDR_PTR);
  assign stat_wr  = RF_WR_I && !null_acc && (eff_file == prgseq_pkg::ADDR_STATUS);
  assign local_acc = null_acc || (eff_file == prgseq_pkg::ADDR_PCL)
                     || (eff_file == prgseq_pkg::ADDR_PTR);

  // ****************************************************************
  // program counter
  // ****************************************************************
  assign ret_addr = {{(prgseq_pkg::STK_W - prgseq_pkg::PC_W){1'b0}}, pc_ff + 10'h001};

  // priority return, call, jump, low-byte write, increment; the decoder
  // issues one at a time, the order only settles illegal overlaps
  always_comb begin
    if (RET_I) begin
      nxt_pc = stk_top[prgseq_pkg::PC_W-1:0];
    end else if (CALL_I) begin
      nxt_pc = {page_ff, 1'b0, BR_ADDR_I[7:0]};
    end else if (JUMP_I) begin
      nxt_pc = {page_ff, BR_ADDR_I[8:0]};
    end else if (pcl_wr) begin
      nxt_pc = {page_ff, 1'b0, RF_WDATA_I};
    end else begin
      nxt_pc = pc_ff + 10'h001;
    end
  end

  // reset points at the calibration word; the next increment wraps to zero
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      pc_ff <= prgseq_pkg::PC_RESET;
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  // page preselect follows writes of status bit 5, cleared by reset
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      page_ff <= prgseq_pkg::PAGE_RESET;
    end else if (stat_wr) begin
      page_ff <= RF_WDATA_I[prgseq_pkg::STAT_PAGE];
    end
  end

  // ****************************************************************
  // return stack
  // ****************************************************************
  // stack has no fullness tracking at all, so nothing can flag over/underflow
  prgseq_stack u_stack (
    .clk_i       (CLK_I),
    .rst_n_i     (RST_N_I),
    .push_i      (CALL_I),
    .pop_i       (RET_I),
    .push_data_i (ret_addr),
    .top_o       (stk_top),
    .lvl2_o      (stk_lvl2)
  );

  // literal of the return goes to the working register one cycle later
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      wload_ff <= 1'b0;
      wdata_ff <= prgseq_pkg::DATA_ZERO;
    end else begin
      wload_ff <= RET_I;
      wdata_ff <= RET_I ? RET_LIT_I : wdata_ff;
    end
  end

  // ****************************************************************
  // indirect pointer and data register file access
  // ****************************************************************
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ptr_ff <= prgseq_pkg::PTR_RESET;
    end else if (ptr_wr) begin
      ptr_ff <= RF_WDATA_I[prgseq_pkg::PTR_W-1:0];
    end
  end

  // stage one: forward non-local accesses to the register file
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      mem_rd_ff    <= 1'b0;
      mem_wr_ff    <= 1'b0;
      mem_addr_ff  <= {prgseq_pkg::MADDR_W{1'b0}};
      mem_wdata_ff <= prgseq_pkg::DATA_ZERO;
    end else begin
      mem_rd_ff    <= RF_RD_I && !local_acc;
      mem_wr_ff    <= RF_WR_I && !local_acc;
      mem_addr_ff  <= eff_addr;
      mem_wdata_ff <= RF_WDATA_I;
    end
  end

  // stage one: remember where read data must come from
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rd_pend_ff  <= 1'b0;
      rd_src_ff   <= prgseq_pkg::PRGSEQ_SRC_MEM;
      pcl_snap_ff <= prgseq_pkg::DATA_ZERO;
    end else begin
      rd_pend_ff  <= RF_RD_I;
      pcl_snap_ff <= pc_ff[7:0];
      if (null_acc) begin
        rd_src_ff <= prgseq_pkg::PRGSEQ_SRC_ZERO;
      end else if (eff_file == prgseq_pkg::ADDR_PCL) begin
        rd_src_ff <= prgseq_pkg::PRGSEQ_SRC_PCL;
      end else if (eff_file == prgseq_pkg::ADDR_PTR) begin
        rd_src_ff <= prgseq_pkg::PRGSEQ_SRC_PTR;
      end else begin
        rd_src_ff <= prgseq_pkg::PRGSEQ_SRC_MEM;
      end
    end
  end

  // stage two: register the answer and hold it until the next one, so the
  // decoder may pick it up late; unused pointer bits read as one
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= prgseq_pkg::DATA_ZERO;
    end else begin
      rd_valid_ff <= rd_pend_ff;
      if (rd_pend_ff) begin
        case (rd_src_ff)
          prgseq_pkg::PRGSEQ_SRC_ZERO: begin
            rd_data_ff <= prgseq_pkg::DATA_ZERO;
          end
          prgseq_pkg::PRGSEQ_SRC_PCL: begin
            rd_data_ff <= pcl_snap_ff;
          end
          prgseq_pkg::PRGSEQ_SRC_PTR: begin
            rd_data_ff <= {{(prgseq_pkg::DATA_W - prgseq_pkg::PTR_W){1'b1}}, ptr_ff};
          end
          default: begin
            rd_data_ff <= MEM_RDATA_I;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign PC_O        = pc_ff;
  assign PAGE_O      = page_ff;
  assign PTR_O       = ptr_ff;
  assign W_LOAD_O    = wload_ff;
  assign W_DATA_O    = wdata_ff;
  assign MEM_RD_O    = mem_rd_ff;
  assign MEM_WR_O    = mem_wr_ff;
  assign MEM_ADDR_O  = mem_addr_ff;
  assign MEM_WDATA_O = mem_wdata_ff;
  assign RD_VALID_O  = rd_valid_ff;
  assign RD_DATA_O   = rd_data_ff;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  logic no_load;
  assign no_load = !RET_I && !CALL_I && !JUMP_I && !pcl_wr;

  pc_incr_a: assert property (no_load |=> PC_O == $past(PC_O) + 10'h001)
    else $error("counter did not advance by one");
  jump_load_a: assert property (JUMP_I && !RET_I && !CALL_I |=> PC_O[8:0] == $past(BR_ADDR_I))
    else $error("jump target bits wrong");
  page_bit_a: assert property ((JUMP_I || CALL_I || pcl_wr) && !RET_I |=> PC_O[9] == $past(page_ff))
    else $error("page bit not applied to counter bit 9");
  call_clear_a: assert property (CALL_I && !RET_I |=> !PC_O[8] && PC_O[7:0] == $past(BR_ADDR_I[7:0]))
    else $error("call target wrong or bit 8 set");
  pcl_write_a: assert property (pcl_wr && !RET_I && !CALL_I && !JUMP_I
                                |=> PC_O[7:0] == $past(RF_WDATA_I) && !PC_O[8])
    else $error("low byte write did not load counter");
  reset_vec_a: assert property ($rose(RST_N_I) |-> PC_O == prgseq_pkg::PC_RESET && !PAGE_O)
    else $error("reset vector or page bit wrong");
  wrap_zero_a: assert property ($rose(RST_N_I) && no_load |=> PC_O == 10'h000)
    else $error("counter did not wrap to zero");
  call_push_a: assert property (CALL_I && !RET_I
                                |=> stk_top == $past(ret_addr) && stk_lvl2 == $past(stk_top))
    else $error("call push order wrong");
  ret_pop_a: assert property (RET_I |=> PC_O == $past(stk_top[9:0]) && stk_top == $past(stk_lvl2)
                              && stk_lvl2 == $past(stk_lvl2))
    else $error("return pop wrong");
  ret_repeat_a: assert property (RET_I ##1 RET_I |=> PC_O == $past(stk_lvl2[9:0], 2))
    else $error("underflow did not repeat level two");
  wreg_load_a: assert property (RET_I |=> W_LOAD_O && W_DATA_O == $past(RET_LIT_I))
    else $error("literal not loaded to working register");
  null_read_a: assert property (RF_RD_I && null_acc |-> ##2 RD_VALID_O && RD_DATA_O == 8'h00)
    else $error("indirect self read not zero");
  null_write_a: assert property (RF_WR_I && null_acc |=> !MEM_WR_O)
    else $error("indirect self write reached memory");
  ind_addr_a: assert property (RF_WR_I && indirect && !local_acc
                               |=> MEM_WR_O && MEM_ADDR_O == $past(ptr_ff))
    else $error("indirect address not taken from pointer");
  pcl_read_a: assert property (RF_RD_I && !indirect && RF_ADDR_I == prgseq_pkg::ADDR_PCL
                               |-> ##2 RD_DATA_O == $past(PC_O[7:0], 2))
    else $error("low byte read wrong");
  rd_hold_a: assert property (!rd_pend_ff |=> $stable(RD_DATA_O))
    else $error("read answer changed without a request");

  call_ret_c:   cover property (CALL_I ##1 !CALL_I [*2] ##1 RET_I);
  deep_call_c:  cover property (CALL_I ##1 CALL_I ##1 CALL_I ##1 RET_I ##1 RET_I ##1 RET_I);
  ind_read_c:   cover property (RF_RD_I && indirect && !null_acc);
  page_jump_c:  cover property (page_ff && JUMP_I);

endmodule
`default_nettype wire

/* File: prgseq_pkg.sv */
// constants shared by the program sequencer and its return stack
package prgseq_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned PC_W     = 10;   // program counter, two pages of 512 words
  localparam int unsigned STK_W    = 12;   // width of one return stack level
  localparam int unsigned DATA_W   = 8;    // data register width
  localparam int unsigned FILE_W   = 5;    // file address field, 32-location window
  localparam int unsigned BANK_W   = 2;    // bank select bits above the window
  localparam int unsigned PTR_W    = FILE_W + BANK_W;
  localparam int unsigned MADDR_W  = FILE_W + BANK_W;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int unsigned PAGE_POS   = 9;   // counter bit fed by the page preselect bit
  localparam int unsigned STAT_PAGE  = 5;   // page preselect bit inside the status byte
  localparam logic [PC_W-1:0]   PC_RESET   = 10'h3FF;  // last word of the last page
  localparam logic [STK_W-1:0]  STK_RESET  = 12'h000;
  localparam logic [PTR_W-1:0]  PTR_RESET  = 7'h00;
  localparam logic              PAGE_RESET = 1'b0;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;

  // ****************************************************************
  // data register addresses owned or watched by the sequencer
  // ****************************************************************
  localparam logic [FILE_W-1:0] ADDR_INDIRECT = 5'h00;  // indirect_access_port
  localparam logic [FILE_W-1:0] ADDR_PCL      = 5'h02;  // pc_low_byte
  localparam logic [FILE_W-1:0] ADDR_STATUS   = 5'h03;
  localparam logic [FILE_W-1:0] ADDR_PTR      = 5'h04;  // indirect_pointer

  // source of read data returned two cycles after a request
  typedef enum logic [1:0] {
    PRGSEQ_SRC_MEM  = 2'b00,
    PRGSEQ_SRC_ZERO = 2'b01,
    PRGSEQ_SRC_PCL  = 2'b10,
    PRGSEQ_SRC_PTR  = 2'b11
  } prgseq_src_t;

endpackage

/* File: prgseq_stack.sv */
// two-level return address stack with registered top
`timescale 1ns/1ps
`default_nettype none
module prgseq_stack (
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         push_i,
  input  wire logic                         pop_i,
  input  wire logic [prgseq_pkg::STK_W-1:0] push_data_i,
  output logic      [prgseq_pkg::STK_W-1:0] top_o,
  output logic      [prgseq_pkg::STK_W-1:0] lvl2_o
);

  logic [prgseq_pkg::STK_W-1:0] lvl1_ff;
  logic [prgseq_pkg::STK_W-1:0] lvl2_ff;

  // push shifts level one down and loses level two; pop copies level two up
  // but leaves it standing, so repeated pops keep returning the same address
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lvl1_ff <= prgseq_pkg::STK_RESET;
      lvl2_ff <= prgseq_pkg::STK_RESET;
    end else if (pop_i) begin
      lvl1_ff <= lvl2_ff;
    end else if (push_i) begin
      lvl2_ff <= lvl1_ff;
      lvl1_ff <= push_data_i;
    end
  end

  assign top_o  = lvl1_ff;
  assign lvl2_o = lvl2_ff;

endmodule
`default_nettype wire

/* File: prgseq_rf_model.sv */
// data register file stand-in that answers the sequencer's strobes
`timescale 1ns/1ps
`default_nettype none
module prgseq_rf_model (
  input  wire logic                           clk_i,
  input  wire logic                           rd_i,
  input  wire logic                           wr_i,
  input  wire logic [prgseq_pkg::MADDR_W-1:0] addr_i,
  input  wire logic [prgseq_pkg::DATA_W-1:0]  wdata_i,
  output logic      [prgseq_pkg::DATA_W-1:0]  rdata_o
);
  logic [prgseq_pkg::DATA_W-1:0] mem_q [128];
  logic [prgseq_pkg::DATA_W-1:0] last_q = 8'h00;

  // read data counts only while the strobe is high; otherwise show the
  // inverse of the last value so a late sample cannot match by luck
  always_comb rdata_o = rd_i ? mem_q[addr_i] : ~last_q;

  // writes land at the edge that ends the strobe cycle
  always @(posedge clk_i) begin
    if (wr_i) mem_q[addr_i] <= wdata_i;
    if (rd_i) last_q <= mem_q[addr_i];
  end
endmodule
`default_nettype wire

/* File: prgseq_tb_top.sv */
// self-checking bench for the program sequencer with a register file model
`timescale 1ns/1ps
`default_nettype none
module prgseq_tb_top;
  logic CLK_I = 1'b0, RST_N_I = 1'b0, JUMP_I = 1'b0, CALL_I = 1'b0, RET_I = 1'b0, RF_RD_I = 1'b0, RF_WR_I = 1'b0;
  logic [8:0] BR_ADDR_I = 9'h000;
  logic [7:0] RET_LIT_I = 8'h00, RF_WDATA_I = 8'h00, MEM_RDATA_I, W_DATA_O, MEM_WDATA_O, RD_DATA_O;
  logic [4:0] RF_ADDR_I = 5'h00;
  logic [9:0] PC_O;
  logic [6:0] PTR_O, MEM_ADDR_O;
  logic       PAGE_O, W_LOAD_O, MEM_RD_O, MEM_WR_O, RD_VALID_O;
  int         n_errors = 0, checks = 0, cycles = 0;
  // ****************************************************************
  // reference state, rows of {jump,call,ret,rd,wr,br,lit,addr,wdata,pc}
  // ****************************************************************
  logic [9:0] m_pc;
  logic [11:0] m_s1, m_s2;
  logic [6:0] m_ptr, m_ma, ea;
  logic [7:0] m_wd, m_rd, m_d1, m_wdat, m_mem [128];
  logic       m_pg, m_wl, m_rv, m_v1, m_mrd, m_mwr, ind, armed = 1'b0;
  logic [4:0] ef;
  localparam logic [47:0] ROWS [28] = '{
    {5'h10, 9'h1AB, 16'h0000, 8'h00, 10'h1AB}, {5'h08, 9'h1C5, 16'h0000, 8'h00, 10'h0C5},
    {5'h08, 9'h010, 16'h0000, 8'h00, 10'h010}, {5'h08, 9'h020, 16'h0000, 8'h00, 10'h020},
    {5'h04, 9'h000, 16'hA500, 8'h00, 10'h011}, {5'h04, 9'h000, 16'h5A00, 8'h00, 10'h0C6},
    {5'h04, 9'h000, 16'h3C00, 8'h00, 10'h0C6}, {5'h00, 9'h000, 16'h0000, 8'h00, 10'h0C7},
    {5'h01, 9'h000, 16'h0003, 8'h20, 10'h0C8}, {5'h10, 9'h0F0, 16'h0000, 8'h00, 10'h2F0},
    {5'h08, 9'h0FF, 16'h0000, 8'h00, 10'h2FF}, {5'h01, 9'h000, 16'h0002, 8'h34, 10'h234},
    {5'h02, 9'h000, 16'h0002, 8'h00, 10'h235}, {5'h04, 9'h000, 16'h0000, 8'h00, 10'h2F1},
    {5'h11, 9'h100, 16'h0003, 8'h00, 10'h300}, {5'h10, 9'h100, 16'h0000, 8'h00, 10'h100},
    {5'h01, 9'h000, 16'h0007, 8'h10, 10'h101}, {5'h01, 9'h000, 16'h0004, 8'hA7, 10'h102},
    {5'h01, 9'h000, 16'h0000, 8'h0A, 10'h103}, {5'h02, 9'h000, 16'h0000, 8'h00, 10'h104},
    {5'h02, 9'h000, 16'h0007, 8'h00, 10'h105}, {5'h01, 9'h000, 16'h0004, 8'h60, 10'h106},
    {5'h01, 9'h000, 16'h0000, 8'hFF, 10'h107}, {5'h02, 9'h000, 16'h0000, 8'h00, 10'h108},
    {5'h02, 9'h000, 16'h0004, 8'h00, 10'h109}, {5'h02, 9'h000, 16'h0003, 8'h00, 10'h10A},
    {5'h01, 9'h000, 16'h0002, 8'hFF, 10'h0FF}, {5'h00, 9'h000, 16'h0000, 8'h00, 10'h100}};

  always #2 CLK_I = ~CLK_I;

  prgseq_top dut_u (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .JUMP_I(JUMP_I), .CALL_I(CALL_I), .RET_I(RET_I),
    .BR_ADDR_I(BR_ADDR_I), .RET_LIT_I(RET_LIT_I), .RF_RD_I(RF_RD_I), .RF_WR_I(RF_WR_I), .RF_ADDR_I(RF_ADDR_I),
    .RF_WDATA_I(RF_WDATA_I), .MEM_RDATA_I(MEM_RDATA_I), .PC_O(PC_O), .PAGE_O(PAGE_O), .PTR_O(PTR_O),
    .W_LOAD_O(W_LOAD_O), .W_DATA_O(W_DATA_O), .MEM_RD_O(MEM_RD_O), .MEM_WR_O(MEM_WR_O),
    .MEM_ADDR_O(MEM_ADDR_O), .MEM_WDATA_O(MEM_WDATA_O), .RD_VALID_O(RD_VALID_O), .RD_DATA_O(RD_DATA_O));
  prgseq_rf_model rf_u (.clk_i(CLK_I), .rd_i(MEM_RD_O), .wr_i(MEM_WR_O), .addr_i(MEM_ADDR_O),
    .wdata_i(MEM_WDATA_O), .rdata_o(MEM_RDATA_I));

  task automatic cmp_word(input string what, input logic [9:0] exp, input logic [9:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_flag(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // reference model; reads are done before the counter and page move,
  // so a same-cycle status write still leaves the old page for the branch
  always @(posedge CLK_I) begin
    armed = 1'b1;
    if (!RST_N_I) begin
      {m_pc, m_pg, m_ptr, m_s1, m_s2} = {10'h3FF, 1'b0, 7'h00, 24'h000000};
      {m_wl, m_wd, m_rv, m_rd, m_v1, m_mrd, m_mwr} = {1'b0, 8'h00, 1'b0, 8'h00, 3'h0};
    end else begin
      m_rv = m_v1;
      if (m_v1) m_rd = m_d1;
      {m_v1, m_wl, m_mrd, m_mwr} = 4'h0;
      ind = (RF_ADDR_I == 5'h00);
      ef = ind ? m_ptr[4:0] : RF_ADDR_I;
      ea = ind ? m_ptr : {2'b00, RF_ADDR_I};
      if (RF_RD_I) begin
        m_v1 = 1'b1;
        if (ef == 5'h00) m_d1 = 8'h00;
        else if (ef == 5'h02) m_d1 = m_pc[7:0];
        else if (ef == 5'h04) m_d1 = {1'b1, m_ptr};
        else {m_mrd, m_ma, m_d1} = {1'b1, ea, m_mem[ea]};
      end
      if (RET_I) {m_pc, m_s1, m_wl, m_wd} = {m_s1[9:0], m_s2, 1'b1, RET_LIT_I};
      else if (CALL_I) {m_s2, m_s1, m_pc} = {m_s1, 2'b00, m_pc + 10'h001, m_pg, 1'b0, BR_ADDR_I[7:0]};
      else if (JUMP_I) m_pc = {m_pg, BR_ADDR_I};
      else if (RF_WR_I && ef == 5'h02) m_pc = {m_pg, 1'b0, RF_WDATA_I};
      else m_pc = m_pc + 10'h001;
      if (RF_WR_I && ef == 5'h04) m_ptr = RF_WDATA_I[6:0];
      else if (RF_WR_I && ef != 5'h02 && ef != 5'h00) begin
        {m_mwr, m_ma, m_wdat} = {1'b1, ea, RF_WDATA_I};
        m_mem[ea] = RF_WDATA_I;
      end
      if (RF_WR_I && ef == 5'h03) m_pg = RF_WDATA_I[5];
    end
  end

  // every output checked mid-cycle against the reference
  always @(negedge CLK_I) begin
    if (armed) begin
      cmp_word("pc", m_pc, PC_O);
      cmp_flag("page", m_pg, PAGE_O);
      cmp_word("pointer", {3'h0, m_ptr}, {3'h0, PTR_O});
      cmp_flag("w load", m_wl, W_LOAD_O);
      cmp_word("w data", {2'h0, m_wd}, {2'h0, W_DATA_O});
      cmp_flag("read valid", m_rv, RD_VALID_O);
      cmp_word("read data", {2'h0, m_rd}, {2'h0, RD_DATA_O});
      cmp_flag("mem write", m_mwr, MEM_WR_O);
      cmp_flag("mem read", m_mrd, MEM_RD_O);
      if (m_mrd | m_mwr) cmp_word("mem addr", {3'h0, m_ma}, {3'h0, MEM_ADDR_O});
      if (m_mwr) cmp_word("mem wdata", {2'h0, m_wdat}, {2'h0, MEM_WDATA_O});
    end
  end

  // the whole run is under a hundred cycles; a hang is cut well after
  always @(posedge CLK_I) begin
    cycles++;
    if (cycles == 400) begin
      n_errors++;
      end_sim();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    for (int i = 0; i <= 28; i++) begin
      @(posedge CLK_I);
      // row layout: flags 47:43, br 42:34, lit 33:26, addr byte 25:18, wdata 17:10, pc 9:0
      if (i < 28) begin
        {JUMP_I, CALL_I, RET_I, RF_RD_I, RF_WR_I, BR_ADDR_I, RET_LIT_I} <= ROWS[i][47:26];
        RF_ADDR_I  <= ROWS[i][22:18];
        RF_WDATA_I <= ROWS[i][17:10];
      end else begin
        {JUMP_I, CALL_I, RET_I, RF_RD_I, RF_WR_I} <= 5'h00;
      end
      @(negedge CLK_I);
      if (i == 0) cmp_word("pc after reset", 10'h000, PC_O);
      else cmp_word("pc row", ROWS[i-1][9:0], PC_O);
    end
    // reset in mid-run with page set, a call stacked and a read in flight
    @(posedge CLK_I);
    {RF_WR_I, RF_ADDR_I, RF_WDATA_I} <= {1'b1, 5'h03, 8'h20};
    @(posedge CLK_I);
    {RF_WR_I, CALL_I, BR_ADDR_I} <= {1'b0, 1'b1, 9'h055};
    @(posedge CLK_I);
    {CALL_I, RF_RD_I, RF_ADDR_I} <= {1'b0, 1'b1, 5'h07};
    @(posedge CLK_I);
    {RF_RD_I, RST_N_I} <= 2'b00;
    @(posedge CLK_I);
    {RST_N_I, RET_I, RET_LIT_I} <= {1'b1, 1'b1, 8'hC3};
    @(posedge CLK_I);
    RET_LIT_I <= 8'h3C;
    @(posedge CLK_I);
    RET_I <= 1'b0;
    repeat (3) @(posedge CLK_I);
    end_sim();
  end
endmodule
`default_nettype wire
